/* File: common/asp_pkg.sv */
// constants and types for the asynchronous serial port, modes 1 to 3
// Function
// - writing the data buffer in modes 1-3 starts a frame on the serial output
// - reception begins only on a high-to-low edge of the serial input
// - frame check select enables framing checks and maps control bit 7 to error flag
// - with checks on, an invalid low stop bit sets the framing error flag
// - framing error flag is sticky; only software clear or reset removes it
// - with checks on, receive done rises in the stop bit, not the last data bit
// - modes 1 and 3 derive receive and transmit rates independently
// - two source select bits choose timer 1 or internal generator per direction
// - internal generator rate follows reload value, prescale bypass and baud double
// - mode 2 rate is peripheral clock over 32, or over 16 with baud double
// - peripheral clock is oscillator over 2 in half-rate mode, else oscillator
// - with multiprocessor enable, ninth bit 0 is data frame, 1 is address frame
// - filtered data frames neither load the buffer nor raise receive done
// - matching address frame sets receive ninth bit and receive done
// - address compare uses bit positions where the mask holds one, or broadcast: ones at every own-or-mask bit
// - modes 2 and 3 frames are 11 bits, data sent lsb first
// - mode 1 frames are 10 bits; received stop bit goes to receive ninth bit
// - receive and transmit done flags ORed into one request, cleared by software
package asp_pkg;
  // register offsets on the plain register port
  localparam logic [2:0] ASP_OFS_CTRL   = 3'h0;
  localparam logic [2:0] ASP_OFS_DATA   = 3'h1;
  localparam logic [2:0] ASP_OFS_POWER  = 3'h2;
  localparam logic [2:0] ASP_OFS_BAUD   = 3'h3;
  localparam logic [2:0] ASP_OFS_RELOAD = 3'h4;
  localparam logic [2:0] ASP_OFS_OWNADR = 3'h5;
  localparam logic [2:0] ASP_OFS_ADRMSK = 3'h6;
  localparam logic [2:0] ASP_OFS_CLKMOD = 3'h7;
  // serial_control_reg fields
  localparam int ASP_CTRL_ERR_M0   = 7;
  localparam int ASP_CTRL_M1       = 6;
  localparam int ASP_CTRL_MPROC    = 5;
  localparam int ASP_CTRL_RXEN     = 4;
  localparam int ASP_CTRL_TX9      = 3;
  localparam int ASP_CTRL_RX9      = 2;
  localparam int ASP_CTRL_TXDONE   = 1;
  localparam int ASP_CTRL_RXDONE   = 0;
  // power_control_reg fields
  localparam int ASP_PWR_DOUBLE    = 7;
  localparam int ASP_PWR_FCHECK    = 6;
  // baud_gen_control_reg fields
  localparam int ASP_BG_ENABLE     = 4;
  localparam int ASP_BG_TXSRC      = 3;
  localparam int ASP_BG_RXSRC      = 2;
  localparam int ASP_BG_BYPASS     = 1;
  // clock mode register field
  localparam int ASP_CLK_FULLRATE  = 0;
  // reset values
  localparam logic [7:0] ASP_RST_BYTE = 8'h00;
  // timing counts in sample ticks and peripheral ticks
  localparam logic [3:0] ASP_OVS_LAST   = 4'hF;  // 16 samples per bit
  localparam logic [3:0] ASP_OVS_MID    = 4'h7;  // mid-bit of the start bit
  localparam logic [2:0] ASP_PRESC_LAST = 3'h5;  // divide by 6 prescaler
  localparam logic [3:0] ASP_RX_NINTH   = 4'h8;  // bit index of ninth bit / mode 1 stop
  localparam logic [3:0] ASP_RX_STOP9   = 4'h9;  // stop bit index in 9-bit modes
  localparam logic [3:0] ASP_TX_LAST10  = 4'h9;  // stop bit index, 10-bit frame
  localparam logic [3:0] ASP_TX_LAST11  = 4'hA;  // stop bit index, 11-bit frame
  typedef enum logic [1:0] {ASP_RX_IDLE, ASP_RX_START, ASP_RX_BITS} asp_rx_state_type;
  typedef enum logic {ASP_TX_IDLE, ASP_TX_SHIFT} asp_tx_state_type;
endpackage

/* File: core/asp_baud_gen.sv */
// bit-rate tick generation for both directions of the serial port
`timescale 1ns/1ps
module asp_baud_gen (
  input  wire logic       clock_in,
  input  wire logic       nrst_in,
  input  wire logic       per_tick_in,
  input  wire logic       timer1_ovf_in,
  input  wire logic       gen_enable_in,
  input  wire logic       prescale_bypass_in,
  input  wire logic [7:0] reload_in,
  input  wire logic       baud_double_in,
  input  wire logic       fixed_rate_in,
  input  wire logic       rx_src_sel_in,
  input  wire logic       tx_src_sel_in,
  output logic            rx_sample_tick_out,
  output logic            tx_sample_tick_out
);
  import asp_pkg::*;
  logic [2:0] presc_ff;
  logic [7:0] reload_cnt_ff;
  logic       gen_ovf_ff;
  logic       rx_half_ff;
  logic       tx_half_ff;
  logic       gen_tick;
  logic       rx_src;
  logic       tx_src;

  // divide by 6 unless bypassed
  assign gen_tick = per_tick_in & (prescale_bypass_in | (presc_ff == ASP_PRESC_LAST));
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      presc_ff <= '0;
    else if (per_tick_in)
      presc_ff <= (presc_ff == ASP_PRESC_LAST) ? 3'h0 : presc_ff + 3'h1;
  end

  // 8-bit auto-reload counter; overflow period is 256 minus reload
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      reload_cnt_ff <= ASP_RST_BYTE;
      gen_ovf_ff    <= 1'b0;
    end
    else
    begin
      gen_ovf_ff <= gen_enable_in & gen_tick & (reload_cnt_ff == 8'hFF);
      if (!gen_enable_in)
        reload_cnt_ff <= reload_in;
      else if (gen_tick)
        reload_cnt_ff <= (reload_cnt_ff == 8'hFF) ? reload_in : reload_cnt_ff + 8'h01;
    end
  end

  // each direction picks its own source; mode 2 runs straight off the peripheral clock
  assign rx_src = fixed_rate_in ? per_tick_in : (rx_src_sel_in ? gen_ovf_ff : timer1_ovf_in);
  assign tx_src = fixed_rate_in ? per_tick_in : (tx_src_sel_in ? gen_ovf_ff : timer1_ovf_in);

  // halving stage skipped by baud double, giving the 16x sample tick
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      rx_half_ff <= 1'b0;
      tx_half_ff <= 1'b0;
    end
    else
    begin
      if (rx_src)
        rx_half_ff <= ~rx_half_ff;
      if (tx_src)
        tx_half_ff <= ~tx_half_ff;
    end
  end
  assign rx_sample_tick_out = rx_src & (baud_double_in | rx_half_ff);
  assign tx_sample_tick_out = tx_src & (baud_double_in | tx_half_ff);
endmodule // asp_baud_gen

/* File: core/asp_core.sv */
// asynchronous serial port core: registers, transmitter, receiver, address filter
`timescale 1ns/1ps
module asp_core (
  input  wire logic       clock_in,
  input  wire logic       nrst_in,
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       wr_strobe_in,
  input  wire logic       rd_strobe_in,
  output logic      [7:0] rd_data_out,
  input  wire logic       timer1_ovf_in,
  input  wire logic       serial_rx_in,
  output logic            serial_tx_out,
  output logic            serial_irq_out
);
  import asp_pkg::*;

  // address match on masked bits, or the broadcast form
  function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] own, input logic [7:0] mask);
    logic [7:0] bcast;
    bcast = own | mask;
    addr_hit = ((rx & mask) == (own & mask)) || ((rx & bcast) == bcast);
  endfunction

  // software registers
  logic       mode0_ff;
  logic       mode1_ff;
  logic       mproc_ff;
  logic       rx_enable_ff;
  logic       tx_ninth_ff;
  logic       rx_ninth_ff;
  logic       tx_done_ff;
  logic       rx_done_ff;
  logic       frame_err_ff;
  logic       baud_double_ff;
  logic       frame_check_ff;
  logic [4:0] baud_ctrl_ff;
  logic [7:0] reload_ff;
  logic [7:0] own_addr_ff;
  logic [7:0] addr_mask_ff;
  logic       full_rate_ff;
  logic [7:0] rx_buf_ff;
  logic [7:0] rd_data_ff;
  // peripheral clock and ticks
  logic       half_phase_ff;
  logic       per_tick;
  logic       rx_tick;
  logic       tx_tick;
  // transmitter
  asp_tx_state_type tx_state_ff;
  logic [10:0] tx_shift_ff;
  logic [3:0]  tx_bit_ff;
  logic [3:0]  tx_ovs_ff;
  logic        tx_line_ff;
  logic        tx_stop_begin;
  // receiver
  asp_rx_state_type rx_state_ff;
  logic       rx_sync1_ff;
  logic       rx_sync2_ff;
  logic       rx_prev_ff;
  logic [3:0] rx_ovs_ff;
  logic [3:0] rx_bit_ff;
  logic [7:0] rx_shift_ff;
  logic       rx_bit8_ff;
  // frame completion terms
  logic       async_mode;
  logic       nine_bit;
  logic       wr_ctrl;
  logic       wr_data;
  logic       rx_sample;
  logic       rx_at_stop;
  logic       rx_finish;
  logic       rx_ninth_val;
  logic       rx_accept;
  logic       frame_err_set;

  assign async_mode = mode0_ff | mode1_ff;
  assign nine_bit   = mode0_ff;
  assign wr_ctrl    = wr_strobe_in & (addr_in == ASP_OFS_CTRL);
  assign wr_data    = wr_strobe_in & (addr_in == ASP_OFS_DATA);

  // peripheral tick: every clock in full-rate mode, every other clock in half-rate mode
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      half_phase_ff <= 1'b0;
    else
      half_phase_ff <= ~half_phase_ff;
  end
  assign per_tick = full_rate_ff | half_phase_ff;

  asp_baud_gen u_baud (
    .clock_in           (clock_in),
    .nrst_in            (nrst_in),
    .per_tick_in        (per_tick),
    .timer1_ovf_in      (timer1_ovf_in),
    .gen_enable_in      (baud_ctrl_ff[ASP_BG_ENABLE]),
    .prescale_bypass_in (baud_ctrl_ff[ASP_BG_BYPASS]),
    .reload_in          (reload_ff),
    .baud_double_in     (baud_double_ff),
    .fixed_rate_in      (mode0_ff & ~mode1_ff),
    .rx_src_sel_in      (baud_ctrl_ff[ASP_BG_RXSRC]),
    .tx_src_sel_in      (baud_ctrl_ff[ASP_BG_TXSRC]),
    .rx_sample_tick_out (rx_tick),
    .tx_sample_tick_out (tx_tick)
  );

  // plain configuration registers
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      mode1_ff       <= 1'b0;
      mproc_ff       <= 1'b0;
      rx_enable_ff   <= 1'b0;
      tx_ninth_ff    <= 1'b0;
      baud_double_ff <= 1'b0;
      frame_check_ff <= 1'b0;
      baud_ctrl_ff   <= 5'h00;
      reload_ff      <= ASP_RST_BYTE;
      own_addr_ff    <= ASP_RST_BYTE;
      addr_mask_ff   <= ASP_RST_BYTE;
      full_rate_ff   <= 1'b0;
    end
    else if (wr_strobe_in)
    begin
      if (addr_in == ASP_OFS_CTRL)
      begin
        mode1_ff     <= wr_data_in[ASP_CTRL_M1];
        mproc_ff     <= wr_data_in[ASP_CTRL_MPROC];
        rx_enable_ff <= wr_data_in[ASP_CTRL_RXEN];
        tx_ninth_ff  <= wr_data_in[ASP_CTRL_TX9];
      end
      else if (addr_in == ASP_OFS_POWER)
      begin
        baud_double_ff <= wr_data_in[ASP_PWR_DOUBLE];
        frame_check_ff <= wr_data_in[ASP_PWR_FCHECK];
      end
      else if (addr_in == ASP_OFS_BAUD)
        baud_ctrl_ff <= wr_data_in[4:0];
      else if (addr_in == ASP_OFS_RELOAD)
        reload_ff <= wr_data_in;
      else if (addr_in == ASP_OFS_OWNADR)
        own_addr_ff <= wr_data_in;
      else if (addr_in == ASP_OFS_ADRMSK)
        addr_mask_ff <= wr_data_in;
      else if (addr_in == ASP_OFS_CLKMOD)
        full_rate_ff <= wr_data_in[ASP_CLK_FULLRATE];
    end
  end

  // bit 7 of the control register: mode bit 0, or the error flag while checks are on
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      mode0_ff <= 1'b0;
    else if (wr_ctrl && !frame_check_ff)
      mode0_ff <= wr_data_in[ASP_CTRL_ERR_M0];
  end

  // sticky framing error; a new error in the clearing cycle wins
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      frame_err_ff <= 1'b0;
    else if (frame_err_set)
      frame_err_ff <= 1'b1;
    else if (wr_ctrl && frame_check_ff && !wr_data_in[ASP_CTRL_ERR_M0])
      frame_err_ff <= 1'b0;
  end

  // done flags: software writes them, hardware set wins over a clear
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      tx_done_ff <= 1'b0;
      rx_done_ff <= 1'b0;
    end
    else
    begin
      tx_done_ff <= (wr_ctrl ? wr_data_in[ASP_CTRL_TXDONE] : tx_done_ff) | tx_stop_begin;
      rx_done_ff <= (wr_ctrl ? wr_data_in[ASP_CTRL_RXDONE] : rx_done_ff) | rx_accept;
    end
  end
  assign serial_irq_out = tx_done_ff | rx_done_ff;

  // read port: data valid only in the cycle after the strobe
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      rd_data_ff <= ASP_RST_BYTE;
    else if (!rd_strobe_in)
      rd_data_ff <= ASP_RST_BYTE;
    else if (addr_in == ASP_OFS_CTRL)
      rd_data_ff <= {frame_check_ff ? frame_err_ff : mode0_ff, mode1_ff, mproc_ff, rx_enable_ff,
                     tx_ninth_ff, rx_ninth_ff, tx_done_ff, rx_done_ff};
    else if (addr_in == ASP_OFS_DATA)
      rd_data_ff <= rx_buf_ff;
    else if (addr_in == ASP_OFS_POWER)
      rd_data_ff <= {baud_double_ff, frame_check_ff, 6'h00};
    else if (addr_in == ASP_OFS_BAUD)
      rd_data_ff <= {3'h0, baud_ctrl_ff};
    else if (addr_in == ASP_OFS_RELOAD)
      rd_data_ff <= reload_ff;
    else if (addr_in == ASP_OFS_OWNADR)
      rd_data_ff <= own_addr_ff;
    else if (addr_in == ASP_OFS_ADRMSK)
      rd_data_ff <= addr_mask_ff;
    else
      rd_data_ff <= {7'h00, full_rate_ff};
  end
  assign rd_data_out = rd_data_ff;

  // transmitter: a buffer write while busy is dropped, also during the stop bit after tx done rises
  assign tx_stop_begin = (tx_state_ff == ASP_TX_SHIFT) && tx_tick && (tx_ovs_ff == ASP_OVS_LAST)
                         && (tx_bit_ff == (nine_bit ? ASP_TX_LAST11 : ASP_TX_LAST10) - 4'h1);
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      tx_state_ff <= ASP_TX_IDLE;
      tx_shift_ff <= 11'h7FF;
      tx_bit_ff   <= 4'h0;
      tx_ovs_ff   <= 4'h0;
      tx_line_ff  <= 1'b1;
    end
    else
    begin
      case (tx_state_ff)
        ASP_TX_IDLE:
        begin
          tx_line_ff <= 1'b1;
          if (wr_data && async_mode)
          begin
            // stop, ninth (or stop again in mode 1), data lsb first, start
            tx_shift_ff <= {1'b1, nine_bit ? tx_ninth_ff : 1'b1, wr_data_in, 1'b0};
            tx_bit_ff   <= 4'h0;
            tx_ovs_ff   <= 4'h0;
            tx_state_ff <= ASP_TX_SHIFT;
          end
        end
        ASP_TX_SHIFT:
        begin
          tx_line_ff <= tx_shift_ff[0];
          if (tx_tick)
          begin
            tx_ovs_ff <= tx_ovs_ff + 4'h1;
            if (tx_ovs_ff == ASP_OVS_LAST)
            begin
              if (tx_bit_ff == (nine_bit ? ASP_TX_LAST11 : ASP_TX_LAST10))
                tx_state_ff <= ASP_TX_IDLE;
              tx_bit_ff   <= tx_bit_ff + 4'h1;
              tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
            end
          end
        end
        default:
          tx_state_ff <= ASP_TX_IDLE;
      endcase
    end
  end
  assign serial_tx_out = tx_line_ff;

  // input synchroniser, then one more stage for the edge detector
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      rx_sync1_ff <= 1'b1;
      rx_sync2_ff <= 1'b1;
      rx_prev_ff  <= 1'b1;
    end
    else
    begin
      rx_sync1_ff <= serial_rx_in;
      rx_sync2_ff <= rx_sync1_ff;
      rx_prev_ff  <= rx_sync2_ff;
    end
  end

  // completion: stop bit when checks are on or in mode 1, else the ninth bit
  assign rx_sample    = (rx_state_ff == ASP_RX_BITS) && rx_tick && (rx_ovs_ff == ASP_OVS_LAST);
  assign rx_at_stop   = rx_bit_ff == (nine_bit ? ASP_RX_STOP9 : ASP_RX_NINTH);
  assign rx_finish    = rx_sample && (rx_at_stop || (nine_bit && !frame_check_ff && rx_bit_ff == ASP_RX_NINTH));
  assign rx_ninth_val = (rx_bit_ff == ASP_RX_NINTH) ? rx_sync2_ff : rx_bit8_ff;
  assign frame_err_set = rx_sample && rx_at_stop && frame_check_ff && !rx_sync2_ff;
  // filter: data frames dropped, address frames kept only on a match
  assign rx_accept = rx_finish && !rx_done_ff &&
                     (!mproc_ff || (rx_ninth_val && addr_hit(rx_shift_ff, own_addr_ff, addr_mask_ff)));

  // receive state machine on the 16x sample tick
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      rx_state_ff <= ASP_RX_IDLE;
      rx_ovs_ff   <= 4'h0;
      rx_bit_ff   <= 4'h0;
      rx_shift_ff <= ASP_RST_BYTE;
      rx_bit8_ff  <= 1'b0;
    end
    else
    begin
      case (rx_state_ff)
        ASP_RX_IDLE:
        begin
          rx_ovs_ff <= 4'h0;
          if (rx_enable_ff && async_mode && rx_prev_ff && !rx_sync2_ff)
            rx_state_ff <= ASP_RX_START;
        end
        ASP_RX_START:
        begin
          if (rx_tick)
          begin
            rx_ovs_ff <= rx_ovs_ff + 4'h1;
            if (rx_ovs_ff == ASP_OVS_MID)
            begin
              // a glitch that is gone by mid-bit is no start bit
              rx_state_ff <= rx_sync2_ff ? ASP_RX_IDLE : ASP_RX_BITS;
              rx_ovs_ff   <= 4'h0;
              rx_bit_ff   <= 4'h0;
            end
          end
        end
        ASP_RX_BITS:
        begin
          if (rx_tick)
            rx_ovs_ff <= rx_ovs_ff + 4'h1;
          if (rx_sample)
          begin
            rx_bit_ff <= rx_bit_ff + 4'h1;
            if (rx_bit_ff < ASP_RX_NINTH)
              rx_shift_ff <= {rx_sync2_ff, rx_shift_ff[7:1]};
            else if (rx_bit_ff == ASP_RX_NINTH)
              rx_bit8_ff <= rx_sync2_ff;
            if (rx_finish)
              rx_state_ff <= ASP_RX_IDLE;
          end
        end
        default:
          rx_state_ff <= ASP_RX_IDLE;
      endcase
    end
  end

  // received byte and ninth bit land only on an accepted frame
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      rx_buf_ff   <= ASP_RST_BYTE;
      rx_ninth_ff <= 1'b0;
    end
    else if (rx_accept)
    begin
      rx_buf_ff   <= rx_shift_ff;
      rx_ninth_ff <= rx_ninth_val;
    end
  end
endmodule // asp_core

/* File: test/asp_core_checker.sv */
// assertion checker watching the serial port core's top-level ports
`timescale 1ns/1ps
module asp_core_checker (
  input wire logic       clock_in,
  input wire logic       nrst_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic       wr_strobe_in,
  input wire logic       rd_strobe_in,
  input wire logic [7:0] rd_data_out,
  input wire logic       timer1_ovf_in,
  input wire logic       serial_rx_in,
  input wire logic       serial_tx_out,
  input wire logic       serial_irq_out
);
  import asp_pkg::*;
  logic fchk_ff;
  logic m0_ff;
  logic rdc_ff;
  logic fe_seen_ff;
  default clocking dc @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // software view of check select, mode bit and a pending control read
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      fchk_ff <= 1'b0;
      m0_ff   <= 1'b0;
      rdc_ff  <= 1'b0;
    end
    else
    begin
      rdc_ff <= rd_strobe_in && addr_in == ASP_OFS_CTRL;
      if (wr_strobe_in && addr_in == ASP_OFS_POWER)
        fchk_ff <= wr_data_in[ASP_PWR_FCHECK];
      if (wr_strobe_in && addr_in == ASP_OFS_CTRL && !fchk_ff)
        m0_ff <= wr_data_in[ASP_CTRL_ERR_M0];
    end
  end
  // conservative: any write that might clear the error flag forgets it
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in || (wr_strobe_in && (addr_in == ASP_OFS_POWER || (addr_in == ASP_OFS_CTRL && !wr_data_in[7]))))
      fe_seen_ff <= 1'b0;
    else if (rdc_ff && fchk_ff && rd_data_out[ASP_CTRL_ERR_M0])
      fe_seen_ff <= 1'b1;
  end
  AST_TX_LOW_HOLD:
    assert property ($fell(serial_tx_out) |=> !serial_tx_out [*8])
    else $error("serial output low for under half a bit");
  AST_TX_HIGH_HOLD:
    assert property ($rose(serial_tx_out) |=> serial_tx_out [*8])
    else $error("serial output high for under half a bit");
  AST_IRQ_STICKY:
    assert property (serial_irq_out && !(wr_strobe_in && addr_in == ASP_OFS_CTRL) |=> serial_irq_out)
    else $error("request dropped without a control write");
  AST_IRQ_SW_SET:
    assert property (wr_strobe_in && addr_in == ASP_OFS_CTRL && wr_data_in[1:0] != 2'b00 |=> serial_irq_out)
    else $error("done flag written high gave no request");
  AST_IRQ_READ_AGREE:
    assert property (rdc_ff |-> (rd_data_out[ASP_CTRL_TXDONE] | rd_data_out[ASP_CTRL_RXDONE]) == $past(serial_irq_out))
    else $error("request differs from the done flags");
  AST_FE_STICKY:
    assert property (rdc_ff && fchk_ff && fe_seen_ff |-> rd_data_out[ASP_CTRL_ERR_M0])
    else $error("framing error flag vanished");
  AST_M0_UNCHECKED:
    assert property (rdc_ff && !fchk_ff |-> rd_data_out[ASP_CTRL_ERR_M0] == m0_ff)
    else $error("bit 7 not the mode bit with checks off");
  AST_RESET_OUT:
    assert property ($rose(nrst_in) |-> serial_tx_out && !serial_irq_out && rd_data_out == 8'h00)
    else $error("outputs not idle after reset");
endmodule // asp_core_checker
bind asp_core asp_core_checker asp_core_checker_inst (
  .clock_in(clock_in), .nrst_in(nrst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out),
  .timer1_ovf_in(timer1_ovf_in), .serial_rx_in(serial_rx_in), .serial_tx_out(serial_tx_out),
  .serial_irq_out(serial_irq_out));

/* File: test/asp_remote_node.sv */
// behavioural remote serial node driving and watching the serial lines
`timescale 1ns/1ps
module asp_remote_node (
  input  wire logic clock_in,
  input  wire logic line_in,
  output logic      line_out,
  output logic      stop_out
);
  // idle line sits high like a pulled-up serial wire
  initial
  begin
    line_out = 1'b1;
    stop_out = 1'b0;
  end
  // start bit, then nbits lsb first; the last one is the stop bit
  task automatic send(input logic [10:0] bits, input int nbits, input int blen);
    line_out <= 1'b0;
    repeat (blen) @(posedge clock_in);
    for (int i = 0; i < nbits; i++)
    begin
      line_out <= bits[i];
      stop_out <= (i == nbits - 1);
      repeat (blen) @(posedge clock_in);
    end
    line_out <= 1'b1;
    stop_out <= 1'b0;
  endtask
  // a low spike too short to be a start bit
  task automatic pulse(input int n);
    line_out <= 1'b0;
    repeat (n) @(posedge clock_in);
    line_out <= 1'b1;
  endtask
  // waits for a start edge, then samples every bit near its middle
  task automatic recv(input int nbits, input int blen, output logic [10:0] bits);
    int n;
    bits = 11'h000;
    n = 0;
    while (line_in !== 1'b0 && n < 8000)
    begin
      @(posedge clock_in);
      n++;
    end
    repeat (blen / 2) @(posedge clock_in);
    for (int i = 0; i <= nbits; i++)
    begin
      bits[i] = line_in;
      if (i < nbits) repeat (blen) @(posedge clock_in);
    end
  endtask
endmodule // asp_remote_node

/* File: test/async_serial_port_modes_1_2_3_test.sv */
// self-checking testbench for the asynchronous serial port core
`timescale 1ns/1ps
module async_serial_port_modes_1_2_3_test;
  import asp_pkg::*;
  logic       clock_in = 1'b0;
  logic       nrst_ff  = 1'b0;
  logic [2:0] addr_ff  = 3'h0;
  logic [7:0] wdata_ff = 8'h00;
  logic       wr_ff    = 1'b0;
  logic       rd_ff    = 1'b0;
  logic       t1_ff    = 1'b0;
  logic [7:0] rd_data;
  logic       tx_line;
  logic       rx_line;
  logic       irq;
  logic       in_stop;
  int         errors = 0;
  int         checks_done = 0;
  asp_core asp_core_inst (.clock_in(clock_in), .nrst_in(nrst_ff), .addr_in(addr_ff), .wr_data_in(wdata_ff),
    .wr_strobe_in(wr_ff), .rd_strobe_in(rd_ff), .rd_data_out(rd_data), .timer1_ovf_in(t1_ff),
    .serial_rx_in(rx_line), .serial_tx_out(tx_line), .serial_irq_out(irq));
  asp_remote_node asp_remote_node_inst (.clock_in(clock_in), .line_in(tx_line), .line_out(rx_line),
    .stop_out(in_stop));
  always #2.5 clock_in = ~clock_in;
  // timer overflow every second clock, so its rate differs from the generator's
  always @(posedge clock_in) t1_ff <= ~t1_ff;
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_ff <= a;
    wdata_ff <= d;
    wr_ff <= 1'b1;
    @(posedge clock_in);
    wr_ff <= 1'b0;
    @(posedge clock_in);
  endtask
  // data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    addr_ff <= a;
    rd_ff <= 1'b1;
    @(posedge clock_in);
    rd_ff <= 1'b0;
    @(negedge clock_in);
    d = rd_data;
    @(posedge clock_in);
  endtask
  task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic t_reset();
    logic [7:0] v;
    for (int a = 0; a < 8; a++)
    begin
      rd(3'(a), v);
      chk("register after reset", v, 8'h00);
    end
    chk("line idle", tx_line, 1'b1);
    chk("request idle", irq, 1'b0);
    $display("reset test done");
  endtask
  // mode 2 at all four clock-mode and doubling settings
  task automatic t_tx_rates();
    logic [10:0] bits;
    logic [7:0]  d;
    int          blen;
    for (int i = 0; i < 4; i++)
    begin
      blen = 16 << (2 - i[1] - i[0]);
      d = 8'h3C + 8'(i);
      wr(ASP_OFS_CLKMOD, {7'h00, i[1]});
      wr(ASP_OFS_POWER, {i[0], 7'h00});
      wr(ASP_OFS_CTRL, {4'b1000, i[0], 3'b000});
      fork
        wr(ASP_OFS_DATA, d);
        asp_remote_node_inst.recv(10, blen, bits);
      join
      chk("mode 2 frame", bits, {1'b1, i[0], d, 1'b0});
      repeat (blen) @(posedge clock_in);
      rd(ASP_OFS_CTRL, d);
      chk("transmit done", d[ASP_CTRL_TXDONE], 1'b1);
      chk("request", irq, 1'b1);
    end
    $display("transmit rate test done");
  endtask
  // mode 1 both ways at once, each direction on its own source
  task automatic t_mode1();
    logic [10:0] bits;
    logic [7:0]  v;
    logic [7:0]  dt;
    logic [7:0]  dr;
    wr(ASP_OFS_CLKMOD, 8'h01);
    wr(ASP_OFS_POWER, 8'h80);
    wr(ASP_OFS_RELOAD, 8'hFF);
    for (int i = 0; i < 2; i++)
    begin
      dt = 8'hC5 + 8'(i);
      dr = 8'h6A - 8'(i);
      wr(ASP_OFS_BAUD, i ? 8'h14 : 8'h1A);
      wr(ASP_OFS_CTRL, 8'h50);
      fork
        begin
          wr(ASP_OFS_DATA, dt);
          asp_remote_node_inst.recv(9, i ? 32 : 16, bits);
        end
        asp_remote_node_inst.send({3'b001, dr}, 9, i ? 96 : 32);
      join
      repeat (40) @(posedge clock_in);
      chk("mode 1 frame", bits, {2'b01, dt, 1'b0});
      rd(ASP_OFS_DATA, v);
      chk("mode 1 byte", v, dr);
      rd(ASP_OFS_CTRL, v);
      chk("stop bit and flags", v[2:0], 3'b111);
    end
    $display("mode 1 test done");
  endtask
  task automatic t_frame_err();
    logic [7:0] v;
    for (int k = 0; k < 3; k++)
    begin
      if (k == 0) wr(ASP_OFS_CTRL, 8'h90);
      if (k == 0) wr(ASP_OFS_POWER, 8'hC0);
      if (k == 2) rd(ASP_OFS_CTRL, v);
      if (k == 2) chk("error cleared", v[7], 1'b0);
      if (k == 2) wr(ASP_OFS_POWER, 8'h80);
      fork
        asp_remote_node_inst.send(k ? 11'h3A5 : 11'h1A5, 10, 16);
        begin
          @(posedge in_stop);
          repeat (4) @(negedge clock_in);
          if (k) chk("done in stop bit", irq, k == 2);
        end
      join
      repeat (8) @(posedge clock_in);
      rd(ASP_OFS_CTRL, v);
      if (k < 2) chk("error flag", v[7], 1'b1);
      wr(ASP_OFS_CTRL, k == 1 ? 8'h10 : 8'h90);
    end
    rd(ASP_OFS_CTRL, v);
    chk("mode bit visible", v[7:6], 2'b10);
    $display("framing error test done");
  endtask
  task automatic t_multiproc();
    logic [7:0] v;
    logic [7:0] last;
    logic       acc;
    logic [8:0] tbl [5] = '{9'h055, 9'h166, 9'h155, 9'h1FE, 9'h033};
    last = 8'hA5;
    wr(ASP_OFS_BAUD, 8'h1E);
    wr(ASP_OFS_OWNADR, 8'h56);
    wr(ASP_OFS_ADRMSK, 8'hFC);
    for (int i = 0; i < 5; i++)
    begin
      acc = (i > 1);
      wr(ASP_OFS_CTRL, i == 4 ? 8'hD0 : 8'hF0);
      asp_remote_node_inst.send({2'b01, tbl[i]}, 10, 16);
      repeat (4) @(posedge clock_in);
      rd(ASP_OFS_CTRL, v);
      chk("done flag", v[0], acc);
      if (acc) chk("ninth bit", v[2], tbl[i][8]);
      if (acc) last = tbl[i][7:0];
      rd(ASP_OFS_DATA, v);
      chk("buffer", v, last);
    end
    wr(ASP_OFS_CTRL, 8'hD2);
    @(negedge clock_in);
    chk("software flag", irq, 1'b1);
    $display("multiprocessor test done");
  endtask
  task automatic t_glitch();
    logic [7:0] v;
    wr(ASP_OFS_CTRL, 8'hD0);
    asp_remote_node_inst.pulse(4);
    repeat (200) @(posedge clock_in);
    rd(ASP_OFS_CTRL, v);
    chk("spike ignored", v[0], 1'b0);
    wr(ASP_OFS_CTRL, 8'hC0);
    asp_remote_node_inst.send(11'h2C3, 10, 16);
    repeat (20) @(posedge clock_in);
    rd(ASP_OFS_CTRL, v);
    chk("receiver off", v[0], 1'b0);
    rd(ASP_OFS_DATA, v);
    chk("buffer kept", v, 8'h33);
    $display("start glitch test done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog sized well above the roughly five thousand cycles of the tests
  initial
  begin
    repeat (30000) @(posedge clock_in);
    errors++;
    test_done();
  end
  initial
  begin
    repeat (10) @(posedge clock_in);
    nrst_ff <= 1'b1;
    @(posedge clock_in);
    t_reset();
    t_tx_rates();
    t_mode1();
    t_frame_err();
    t_multiproc();
    t_glitch();
    test_done();
  end
endmodule // async_serial_port_modes_1_2_3_test
